/* hdl/cpurs_pkg.sv */
// Constants, encodings and carrier types of the CPU register set
package cpurs_pkg;

	// Reset values and fixed addresses
	localparam logic [15:0] SP_RESET    = 16'h00ff;
	localparam logic [7:0]  SP_LOW_SET  = 8'hff;
	localparam logic [15:0] VEC_RESET   = 16'hfffe;
	localparam logic [15:0] VEC_IRQ_TOP = 16'hfffc;
	localparam logic [7:0]  CCR_ONES    = 8'h60;
	localparam logic [7:0]  CCR_RESET   = 8'h68;

	// Flag register bit positions
	localparam int CCR_V = 7;
	localparam int CCR_H = 4;
	localparam int CCR_I = 3;
	localparam int CCR_N = 2;
	localparam int CCR_Z = 1;
	localparam int CCR_C = 0;

	// Byte counts of the stack and vector transfers
	localparam logic [2:0] INT_BYTES  = 3'h5;
	localparam logic [2:0] CALL_BYTES = 3'h2;
	localparam logic [2:0] VEC_BYTES  = 3'h2;

	// Stack slots, in push order
	localparam logic [2:0] SLOT_PCL = 3'h0;
	localparam logic [2:0] SLOT_PCH = 3'h1;
	localparam logic [2:0] SLOT_X   = 3'h2;
	localparam logic [2:0] SLOT_A   = 3'h3;
	localparam logic [2:0] SLOT_CCR = 3'h4;

	// Register port offsets
	localparam logic [3:0] REG_ACC    = 4'h0;
	localparam logic [3:0] REG_IDX_HI = 4'h1;
	localparam logic [3:0] REG_IDX_LO = 4'h2;
	localparam logic [3:0] REG_SP_HI  = 4'h3;
	localparam logic [3:0] REG_SP_LO  = 4'h4;
	localparam logic [3:0] REG_IP_HI  = 4'h5;
	localparam logic [3:0] REG_IP_LO  = 4'h6;
	localparam logic [3:0] REG_FLAGS  = 4'h7;
	localparam logic [3:0] REG_STATUS = 4'h8;

	localparam int IRQ_IDX_W = 3;

	typedef enum logic [1:0] {
		ST_FETCH = 2'h0,
		ST_IDLE  = 2'h1,
		ST_PUSH  = 2'h3,
		ST_PULL  = 2'h2
	} cpurs_state_t;

	typedef enum logic [4:0] {
		OP_NOP, OP_FETCH, OP_JUMP, OP_ADD, OP_ADC, OP_SUB, OP_AND,
		OP_LDA, OP_LSL, OP_RSP, OP_CLI, OP_LDHX, OP_CALL, OP_RET,
		OP_RTI, OP_EA_SP8, OP_EA_SP16, OP_EA_IX
	} cpurs_op_t;

	typedef struct packed {
		cpurs_op_t   op;
		logic [7:0]  operand;
		logic [15:0] target;
	} cpurs_cmd_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} cpurs_mem_t;

	typedef struct packed {
		cpurs_state_t st;
		logic [7:0]   a;
		logic [7:0]   h;
		logic [7:0]   x;
		logic [15:0]  sp;
		logic [15:0]  pc;
		logic [7:0]   flag_register;
		logic [15:0]  ea;
		logic [15:0]  vec_addr;
		logic [15:0]  target;
		logic [2:0]   nbytes;
		logic [2:0]   cnt;
		logic [2:0]   cap;
		logic [IRQ_IDX_W-1:0] irq_idx;
		logic         is_int;
		logic         irq_ack;
		logic         dv;
		logic [7:0]   vhi;
		logic [7:0]   rd_data;
		cpurs_mem_t   mem;
	} cpurs_regs_t;

	localparam cpurs_regs_t REGS_RESET = '{st: ST_FETCH, sp: SP_RESET,
		flag_register: CCR_RESET, vec_addr: VEC_RESET, default: '0};

endpackage

/* hdl/cpurs_core.sv */
// CPU register set: accumulator, index pair, stack, program counter, flags
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// Function
// - Stack pointer resets to 00FF, next free
// - Reset-stack instruction sets low byte FF
// - Push decrements, pull increments stack pointer
// - Interrupt stacks five bytes, never upper index
// - Call pushes two-byte return, return pulls
// - Reset loads pointer from top vector, high first
// - Fetch increments pointer; jumps load target
// - Flag register bits 6 and 5 read one
// - Signed-wrap flag marks two's complement overflow
// - Nibble carry on add from bit 3
// - Mask blocks interrupts; set after stacking
// - Reset sets mask; only unmask or interrupt return clears
// - Interrupt return restores state including mask
// - Highest-priority pending request served first
// - Top-bit flag copies result bit 7
// - All-clear flag set on zero result
// - Borrow flag from carry, borrow or shift
// - Eight-bit accumulator holds operands and results
// - Sixteen-bit index pair forms indexed address
// - Stack-relative address is pointer plus offset
module cpurs_core #(
	parameter int N_IRQ = 8
) (
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_reset_n,
	// Command port
	input  wire cpurs_pkg::cpurs_cmd_t i_cmd,
	input  wire logic                  i_cmd_valid,
	output logic                       o_cmd_ready,
	// Interrupt requests, bit 0 has the highest priority
	input  wire logic [N_IRQ-1:0]      i_irq,
	output logic                       o_irq_ack,
	output logic [2:0]                 o_irq_idx,
	// Memory bus, read data one cycle after the strobe
	output cpurs_pkg::cpurs_mem_t      o_mem,
	input  wire logic [7:0]            i_mem_rdata,
	// Register port
	input  wire logic [3:0]            i_reg_addr,
	input  wire logic [7:0]            i_reg_wdata,
	input  wire logic                  i_reg_wr,
	input  wire logic                  i_reg_rd,
	output logic [7:0]                 o_reg_rdata,
	// Effective address of the last address command
	output logic [15:0]                o_ea
);

	generate
		if (N_IRQ < 1 || N_IRQ > (1 << cpurs_pkg::IRQ_IDX_W)) begin : g_chk
			$error("N_IRQ out of range");
		end
	endgenerate

	cpurs_pkg::cpurs_regs_t r_reg;
	cpurs_pkg::cpurs_regs_t r_next;
	logic [2:0]             pri_idx;
	logic                   irq_take;
	logic                   take;
	logic                   upd_nz;
	logic                   cin;
	logic                   mask_keep;
	logic [8:0]             sum9;
	logic [4:0]             half5;
	logic [8:0]             diff9;
	logic [7:0]             b;
	logic [2:0]             slot;

	// Lowest set request index wins
	always_comb begin
		pri_idx = 3'h0;
		for (int k = N_IRQ - 1; k >= 0; k--) begin
			if (i_irq[k]) begin
				pri_idx = k[2:0];
			end
		end
	end

	assign irq_take = (r_reg.st == cpurs_pkg::ST_IDLE) && (|i_irq) &&
		!r_reg.flag_register[cpurs_pkg::CCR_I];
	assign o_cmd_ready = (r_reg.st == cpurs_pkg::ST_IDLE) && !irq_take;
	assign take = i_cmd_valid && o_cmd_ready;

	function automatic logic [7:0] stack_byte(
		input cpurs_pkg::cpurs_regs_t s,
		input logic [2:0]             sl
	);
		logic [7:0] v;
		v = 8'h00;
		case (sl)
			cpurs_pkg::SLOT_PCL: v = s.pc[7:0];
			cpurs_pkg::SLOT_PCH: v = s.pc[15:8];
			cpurs_pkg::SLOT_X:   v = s.x;
			cpurs_pkg::SLOT_A:   v = s.a;
			cpurs_pkg::SLOT_CCR: v = s.flag_register;
			default:             v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb begin
		r_next = r_reg;
		r_next.mem.we = 1'b0;
		r_next.mem.re = 1'b0;
		r_next.dv = r_reg.mem.re;
		r_next.irq_ack = 1'b0;
		r_next.rd_data = 8'h00;
		upd_nz = 1'b0;
		b = i_cmd.operand;
		cin = (i_cmd.op == cpurs_pkg::OP_ADC) && r_reg.flag_register[cpurs_pkg::CCR_C];
		sum9 = {1'b0, r_reg.a} + {1'b0, b} + {8'h00, cin};
		half5 = {1'b0, r_reg.a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		diff9 = {1'b0, r_reg.a} - {1'b0, b};
		slot = 3'h0;
		unique case (r_reg.st)
			cpurs_pkg::ST_FETCH: begin
				// Vector read, high byte address first
				if (r_reg.cnt != cpurs_pkg::VEC_BYTES) begin
					r_next.mem.re = 1'b1;
					r_next.mem.addr = r_reg.vec_addr + {13'h0, r_reg.cnt};
					r_next.cnt = r_reg.cnt + 3'h1;
				end
				if (r_reg.dv) begin
					r_next.cap = r_reg.cap + 3'h1;
					if (r_reg.cap == 3'h0) begin
						r_next.vhi = i_mem_rdata;
					end else begin
						r_next.pc = {r_reg.vhi, i_mem_rdata};
						r_next.st = cpurs_pkg::ST_IDLE;
						r_next.irq_ack = r_reg.is_int;
					end
				end
			end
			cpurs_pkg::ST_PUSH: begin
				// Write at the free location, then step down
				slot = r_reg.cnt;
				r_next.mem.we = 1'b1;
				r_next.mem.addr = r_reg.sp;
				r_next.mem.wdata = stack_byte(r_reg, slot);
				r_next.sp = r_reg.sp - 16'h0001;
				r_next.cnt = r_reg.cnt + 3'h1;
				if (r_reg.cnt == r_reg.nbytes - 3'h1) begin
					r_next.cnt = 3'h0;
					r_next.cap = 3'h0;
					if (r_reg.is_int) begin
						// Mask rises after stacking, before vector read
						r_next.flag_register[cpurs_pkg::CCR_I] = 1'b1;
						r_next.st = cpurs_pkg::ST_FETCH;
					end else begin
						r_next.pc = r_reg.target;
						r_next.st = cpurs_pkg::ST_IDLE;
					end
				end
			end
			cpurs_pkg::ST_PULL: begin
				// Reads are pipelined; capture trails by two cycles
				if (r_reg.cnt != r_reg.nbytes) begin
					r_next.sp = r_reg.sp + 16'h0001;
					r_next.mem.re = 1'b1;
					r_next.mem.addr = r_reg.sp + 16'h0001;
					r_next.cnt = r_reg.cnt + 3'h1;
				end
				if (r_reg.dv) begin
					slot = r_reg.nbytes - 3'h1 - r_reg.cap;
					case (slot)
						cpurs_pkg::SLOT_PCL: r_next.pc[7:0] = i_mem_rdata;
						cpurs_pkg::SLOT_PCH: r_next.pc[15:8] = i_mem_rdata;
						cpurs_pkg::SLOT_X:   r_next.x = i_mem_rdata;
						cpurs_pkg::SLOT_A:   r_next.a = i_mem_rdata;
						// Mask comes back with the other flags
						cpurs_pkg::SLOT_CCR: r_next.flag_register = i_mem_rdata;
						default: r_next.a = r_reg.a;
					endcase
					r_next.cap = r_reg.cap + 3'h1;
					if (r_reg.cap == r_reg.nbytes - 3'h1) begin
						r_next.cnt = 3'h0;
						r_next.cap = 3'h0;
						r_next.st = cpurs_pkg::ST_IDLE;
					end
				end
			end
			cpurs_pkg::ST_IDLE: begin
				if (irq_take) begin
					r_next.st = cpurs_pkg::ST_PUSH;
					r_next.is_int = 1'b1;
					r_next.nbytes = cpurs_pkg::INT_BYTES;
					r_next.cnt = 3'h0;
					r_next.irq_idx = pri_idx;
					r_next.vec_addr = cpurs_pkg::VEC_IRQ_TOP -
						{12'h000, pri_idx, 1'b0};
				end else if (take) begin
					case (i_cmd.op)
						cpurs_pkg::OP_NOP: r_next.st = cpurs_pkg::ST_IDLE;
						cpurs_pkg::OP_FETCH: begin
							r_next.pc = r_reg.pc + 16'h0001;
						end
						cpurs_pkg::OP_JUMP: r_next.pc = i_cmd.target;
						cpurs_pkg::OP_ADD, cpurs_pkg::OP_ADC: begin
							r_next.a = sum9[7:0];
							r_next.flag_register[cpurs_pkg::CCR_C] = sum9[8];
							r_next.flag_register[cpurs_pkg::CCR_H] = half5[4];
							r_next.flag_register[cpurs_pkg::CCR_V] = (r_reg.a[7] == b[7]) &&
								(sum9[7] != r_reg.a[7]);
							upd_nz = 1'b1;
						end
						cpurs_pkg::OP_SUB: begin
							r_next.a = diff9[7:0];
							r_next.flag_register[cpurs_pkg::CCR_C] = diff9[8];
							r_next.flag_register[cpurs_pkg::CCR_V] = (r_reg.a[7] != b[7]) &&
								(diff9[7] != r_reg.a[7]);
							upd_nz = 1'b1;
						end
						cpurs_pkg::OP_AND: begin
							r_next.a = r_reg.a & b;
							r_next.flag_register[cpurs_pkg::CCR_V] = 1'b0;
							upd_nz = 1'b1;
						end
						cpurs_pkg::OP_LDA: begin
							r_next.a = b;
							r_next.flag_register[cpurs_pkg::CCR_V] = 1'b0;
							upd_nz = 1'b1;
						end
						cpurs_pkg::OP_LSL: begin
							r_next.a = {r_reg.a[6:0], 1'b0};
							r_next.flag_register[cpurs_pkg::CCR_C] = r_reg.a[7];
							r_next.flag_register[cpurs_pkg::CCR_V] = r_reg.a[7] ^ r_reg.a[6];
							upd_nz = 1'b1;
						end
						cpurs_pkg::OP_RSP: begin
							r_next.sp[7:0] = cpurs_pkg::SP_LOW_SET;
						end
						cpurs_pkg::OP_CLI: begin
							r_next.flag_register[cpurs_pkg::CCR_I] = 1'b0;
						end
						cpurs_pkg::OP_LDHX: begin
							{r_next.h, r_next.x} = i_cmd.target;
						end
						cpurs_pkg::OP_CALL: begin
							r_next.st = cpurs_pkg::ST_PUSH;
							r_next.is_int = 1'b0;
							r_next.nbytes = cpurs_pkg::CALL_BYTES;
							r_next.target = i_cmd.target;
							r_next.cnt = 3'h0;
						end
						cpurs_pkg::OP_RET, cpurs_pkg::OP_RTI: begin
							r_next.st = cpurs_pkg::ST_PULL;
							r_next.nbytes = (i_cmd.op == cpurs_pkg::OP_RTI) ?
								cpurs_pkg::INT_BYTES : cpurs_pkg::CALL_BYTES;
							r_next.cnt = 3'h0;
							r_next.cap = 3'h0;
						end
						cpurs_pkg::OP_EA_SP8: begin
							r_next.ea = r_reg.sp + {8'h00, b};
						end
						cpurs_pkg::OP_EA_SP16: begin
							r_next.ea = r_reg.sp + i_cmd.target;
						end
						cpurs_pkg::OP_EA_IX: begin
							r_next.ea = {r_reg.h, r_reg.x} + i_cmd.target;
						end
						default: r_next.st = cpurs_pkg::ST_IDLE;
					endcase
				end
			end
		endcase
		// Other flags untouched unless the operation names them
		if (upd_nz) begin
			r_next.flag_register[cpurs_pkg::CCR_N] = r_next.a[7];
			r_next.flag_register[cpurs_pkg::CCR_Z] = (r_next.a == 8'h00);
		end
		// Software writes win over the core in the same cycle, except clearing the mask
		mask_keep = r_next.flag_register[cpurs_pkg::CCR_I];
		if (i_reg_wr) begin
			case (i_reg_addr)
				cpurs_pkg::REG_ACC:    r_next.a = i_reg_wdata;
				cpurs_pkg::REG_IDX_HI: r_next.h = i_reg_wdata;
				cpurs_pkg::REG_IDX_LO: r_next.x = i_reg_wdata;
				cpurs_pkg::REG_FLAGS: begin
					// Software may set the mask but never clear it
					r_next.flag_register = i_reg_wdata;
					r_next.flag_register[cpurs_pkg::CCR_I] = i_reg_wdata[cpurs_pkg::CCR_I] |
						mask_keep;
				end
				default: r_next.rd_data = 8'h00;
			endcase
		end
		r_next.flag_register = r_next.flag_register | cpurs_pkg::CCR_ONES;
		if (i_reg_rd) begin
			case (i_reg_addr)
				cpurs_pkg::REG_ACC:    r_next.rd_data = r_reg.a;
				cpurs_pkg::REG_IDX_HI: r_next.rd_data = r_reg.h;
				cpurs_pkg::REG_IDX_LO: r_next.rd_data = r_reg.x;
				cpurs_pkg::REG_SP_HI:  r_next.rd_data = r_reg.sp[15:8];
				cpurs_pkg::REG_SP_LO:  r_next.rd_data = r_reg.sp[7:0];
				cpurs_pkg::REG_IP_HI:  r_next.rd_data = r_reg.pc[15:8];
				cpurs_pkg::REG_IP_LO:  r_next.rd_data = r_reg.pc[7:0];
				cpurs_pkg::REG_FLAGS:  r_next.rd_data = r_reg.flag_register;
				cpurs_pkg::REG_STATUS: r_next.rd_data = {5'h00, irq_take,
					r_reg.st};
				default:               r_next.rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r_reg <= cpurs_pkg::REGS_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_mem = r_reg.mem;
	assign o_irq_ack = r_reg.irq_ack;
	assign o_irq_idx = r_reg.irq_idx;
	assign o_reg_rdata = r_reg.rd_data;
	assign o_ea = r_reg.ea;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_push5;
		(r_reg.st == cpurs_pkg::ST_PUSH) [*5];
	endsequence

	sequence s_pull7;
		(r_reg.st == cpurs_pkg::ST_PULL) [*7];
	endsequence

	a_ccr_ones: assert property (
		r_reg.flag_register[6:5] == 2'b11
	) else $error("flag bits 6 and 5 not one");

	a_rsp_low_byte: assert property (
		take && i_cmd.op == cpurs_pkg::OP_RSP |=>
		r_reg.sp[7:0] == cpurs_pkg::SP_LOW_SET &&
		r_reg.sp[15:8] == $past(r_reg.sp[15:8])
	) else $error("reset-stack result wrong");

	a_push_dec: assert property (
		r_reg.st == cpurs_pkg::ST_PUSH |=> r_reg.sp == $past(r_reg.sp) - 16'h0001
	) else $error("push did not decrement");

	a_int_stack_five: assert property (
		irq_take |=> s_push5 ##1 (r_reg.st == cpurs_pkg::ST_FETCH &&
		r_reg.flag_register[cpurs_pkg::CCR_I] && r_reg.sp == $past(r_reg.sp, 6) - 16'h0005)
	) else $error("interrupt stacking wrong");

	a_call_two: assert property (
		take && i_cmd.op == cpurs_pkg::OP_CALL |=>
		(r_reg.st == cpurs_pkg::ST_PUSH) [*2] ##1
		(r_reg.st == cpurs_pkg::ST_IDLE && r_reg.pc == $past(i_cmd.target, 3))
	) else $error("call sequence wrong");

	a_rti_restore: assert property (
		take && i_cmd.op == cpurs_pkg::OP_RTI |=> s_pull7 ##1
		(r_reg.st == cpurs_pkg::ST_IDLE &&
		r_reg.sp == $past(r_reg.sp, 8) + 16'h0005)
	) else $error("interrupt return wrong");

	a_mask_blocks: assert property (
		r_reg.st == cpurs_pkg::ST_IDLE && r_reg.flag_register[cpurs_pkg::CCR_I] |=>
		!(r_reg.st == cpurs_pkg::ST_PUSH && r_reg.is_int)
	) else $error("masked interrupt taken");

	a_mask_clear: assert property (
		$fell(r_reg.flag_register[cpurs_pkg::CCR_I]) |->
		$past(take && i_cmd.op == cpurs_pkg::OP_CLI) ||
		$past(r_reg.st == cpurs_pkg::ST_PULL && r_reg.dv)
	) else $error("mask cleared by other cause");

	a_nz_flags: assert property (
		take && !i_reg_wr && i_cmd.op inside {cpurs_pkg::OP_ADD,
		cpurs_pkg::OP_SUB, cpurs_pkg::OP_AND, cpurs_pkg::OP_LDA} |=>
		r_reg.flag_register[cpurs_pkg::CCR_N] == r_reg.a[7] &&
		r_reg.flag_register[cpurs_pkg::CCR_Z] == (r_reg.a == 8'h00)
	) else $error("result flags wrong");

	a_flags_keep: assert property (
		take && !i_reg_wr && i_cmd.op inside {cpurs_pkg::OP_FETCH,
		cpurs_pkg::OP_JUMP, cpurs_pkg::OP_RSP, cpurs_pkg::OP_LDHX} |=>
		$stable(r_reg.flag_register)
	) else $error("flags changed");

	a_fetch_inc: assert property (
		take && i_cmd.op == cpurs_pkg::OP_FETCH |=>
		r_reg.pc == $past(r_reg.pc) + 16'h0001
	) else $error("fetch did not advance");

	a_ea_stack: assert property (
		take && i_cmd.op == cpurs_pkg::OP_EA_SP8 |=>
		r_reg.ea == $past(r_reg.sp) + {8'h00, $past(i_cmd.operand)}
	) else $error("stack-relative address wrong");

endmodule

/* dv/cpurs_tb.sv */
// Self-checking bench of the CPU register set
`timescale 1ns/1ps
module testbench;
	logic                  i_clk = 1'b0;
	logic                  i_reset_n = 1'b0;
	cpurs_pkg::cpurs_cmd_t i_cmd = '0;
	logic                  i_cmd_valid = 1'b0;
	logic                  o_cmd_ready;
	logic [7:0]            i_irq = 8'h00;
	logic                  o_irq_ack;
	logic [2:0]            o_irq_idx;
	cpurs_pkg::cpurs_mem_t o_mem;
	logic [7:0]            i_mem_rdata = 8'h00;
	logic [3:0]            i_reg_addr = 4'h0;
	logic [7:0]            i_reg_wdata = 8'h00;
	logic                  i_reg_wr = 1'b0;
	logic                  i_reg_rd = 1'b0;
	logic [7:0]            o_reg_rdata;
	logic [15:0]           o_ea;
	logic [7:0]            mem [logic [15:0]];
	int                    fail_count = 0;
	int                    n_compared = 0;
	int                    n_wr = 0;
	int                    n_ack = 0;
	logic [2:0]            ack_idx = 3'h0;
	logic [7:0]            fl;
	logic [7:0]            acc;
	logic [7:0]            b;
	logic [7:0]            d8;
	logic [15:0]           sp;
	logic [15:0]           pc;
	logic [15:0]           v;
	logic [15:0]           t;
	logic [39:0]           e;
	logic [2:0]            k;
	logic [23:0]           corner [4] = '{24'h7f0100, 24'h800102,
		24'hff0100, 24'h000102};
	cpurs_pkg::cpurs_op_t  ops [8] = '{cpurs_pkg::OP_ADD, cpurs_pkg::OP_ADC,
		cpurs_pkg::OP_SUB, cpurs_pkg::OP_AND, cpurs_pkg::OP_LDA,
		cpurs_pkg::OP_LSL, cpurs_pkg::OP_NOP, cpurs_pkg::OP_FETCH};

	always #25 i_clk = ~i_clk;

	cpurs_core #(
		.N_IRQ(8)
	) cpurs_core_i (
		.i_clk      (i_clk),
		.i_reset_n  (i_reset_n),
		.i_cmd      (i_cmd),
		.i_cmd_valid(i_cmd_valid),
		.o_cmd_ready(o_cmd_ready),
		.i_irq      (i_irq),
		.o_irq_ack  (o_irq_ack),
		.o_irq_idx  (o_irq_idx),
		.o_mem      (o_mem),
		.i_mem_rdata(i_mem_rdata),
		.i_reg_addr (i_reg_addr),
		.i_reg_wdata(i_reg_wdata),
		.i_reg_wr   (i_reg_wr),
		.i_reg_rd   (i_reg_rd),
		.o_reg_rdata(o_reg_rdata),
		.o_ea       (o_ea)
	);

	// Memory answers one cycle after a read strobe; idle data keeps toggling
	always @(posedge i_clk) begin
		if (o_mem.re)
			i_mem_rdata <= mem.exists(o_mem.addr) ? mem[o_mem.addr] : 8'h5a;
		else
			i_mem_rdata <= ~i_mem_rdata;
		if (o_mem.we) begin
			mem[o_mem.addr] = o_mem.wdata;
			n_wr++;
		end
		if (o_irq_ack === 1'b1) begin
			ack_idx = o_irq_idx;
			n_ack++;
		end
	end

	task automatic chk8(input string nm, input logic [7:0] x,
		input logic [7:0] g);
		n_compared++;
		if (g !== x) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic chk16(input string nm, input logic [15:0] x,
		input logic [15:0] g);
		n_compared++;
		if (g !== x) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		@(negedge i_clk);
		d = o_reg_rdata;
	endtask

	task automatic rd16(input logic [3:0] a, output logic [15:0] d);
		rd(a, d[15:8]);
		rd(a + 4'h1, d[7:0]);
	endtask

	task automatic idle();
		int n;
		n = 0;
		@(negedge i_clk);
		while (o_cmd_ready !== 1'b1 && n < 40) begin
			@(negedge i_clk);
			n++;
		end
	endtask

	// Ready is combinational, so it is sampled mid-cycle, not at the edge
	task automatic cmd(input cpurs_pkg::cpurs_op_t op, input logic [7:0] o,
		input logic [15:0] tg);
		logic r;
		r = 1'b0;
		@(posedge i_clk);
		i_cmd <= '{op: op, operand: o, target: tg};
		i_cmd_valid <= 1'b1;
		while (r !== 1'b1) begin
			@(negedge i_clk);
			r = o_cmd_ready;
			@(posedge i_clk);
		end
		i_cmd_valid <= 1'b0;
		idle();
	endtask

	task automatic chk_regs();
		logic [15:0] d;
		rd16(cpurs_pkg::REG_SP_HI, d);
		chk16("stack_pointer", sp, d);
		rd16(cpurs_pkg::REG_IP_HI, d);
		chk16("instruction_pointer", pc, d);
		rd(cpurs_pkg::REG_FLAGS, d[7:0]);
		chk8("flag_register", fl, d[7:0]);
		rd(cpurs_pkg::REG_ACC, d[7:0]);
		chk8("accumulator", acc, d[7:0]);
	endtask

	task automatic do_reset();
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		idle();
		sp = 16'h00ff;
		pc = {mem[16'hfffe], mem[16'hffff]};
		fl = 8'h68;
		acc = 8'h00;
		chk_regs();
	endtask

	function automatic logic [15:0] alu(input cpurs_pkg::cpurs_op_t op,
		input logic [7:0] a, input logic [7:0] d, input logic [7:0] f);
		logic [8:0] s;
		logic [4:0] h;
		logic       ci;
		ci = (op == cpurs_pkg::OP_ADC) && f[0];
		s = {1'b0, a} + {1'b0, d} + {8'h00, ci};
		h = {1'b0, a[3:0]} + {1'b0, d[3:0]} + {4'h0, ci};
		case (op)
			cpurs_pkg::OP_ADD, cpurs_pkg::OP_ADC: begin
				f[7] = (a[7] == d[7]) && (s[7] != a[7]);
				f[4] = h[4];
				f[0] = s[8];
			end
			cpurs_pkg::OP_SUB: begin
				s = {1'b0, a} - {1'b0, d};
				f[7] = (a[7] != d[7]) && (s[7] != a[7]);
				f[0] = s[8];
			end
			cpurs_pkg::OP_AND: begin
				s = {1'b0, a & d};
				f[7] = 1'b0;
			end
			cpurs_pkg::OP_LDA: begin
				s = {1'b0, d};
				f[7] = 1'b0;
			end
			cpurs_pkg::OP_LSL: begin
				s = {a, 1'b0};
				f[7] = a[7] ^ a[6];
				f[0] = a[7];
			end
			default: return {a, f};
		endcase
		f[2] = s[7];
		f[1] = (s[7:0] == 8'h00);
		return {s[7:0], f};
	endfunction

	task automatic close_out();
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (9000) @(posedge i_clk);
		fail_count++;
		close_out();
	end

	initial begin
		void'($urandom(32'hb5491ae1));
		mem[16'hfffe] = 8'($urandom);
		mem[16'hffff] = 8'($urandom);
		mem[16'hfffa] = 8'($urandom);
		mem[16'hfffb] = 8'($urandom);
		do_reset();
		for (int i = 0; i < 48; i++) begin
			k = (i < 4) ? corner[i][2:0] : 3'($urandom_range(7));
			b = 8'($urandom);
			wr(cpurs_pkg::REG_FLAGS, b);
			fl = b | 8'h60 | (fl & 8'h08);
			acc = (i < 4) ? corner[i][23:16] : 8'($urandom);
			wr(cpurs_pkg::REG_ACC, acc);
			b = (i < 4) ? corner[i][15:8] : 8'($urandom);
			{acc, fl} = alu(ops[k], acc, b, fl);
			if (ops[k] == cpurs_pkg::OP_FETCH)
				pc = pc + 16'h1;
			cmd(ops[k], b, 16'($urandom));
			rd(cpurs_pkg::REG_ACC, d8);
			chk8("accumulator", acc, d8);
			rd(cpurs_pkg::REG_FLAGS, d8);
			chk8("signed_wrap", 8'(fl[7]), 8'(d8[7]));
			chk8("nibble_carry", 8'(fl[4]), 8'(d8[4]));
			chk8("top_bit", 8'(fl[2]), 8'(d8[2]));
			chk8("all_clear", 8'(fl[1]), 8'(d8[1]));
			chk8("borrow", 8'(fl[0]), 8'(d8[0]));
			chk8("flag_register", fl, d8);
		end
		wr(cpurs_pkg::REG_SP_LO, 8'h12);
		// Stack pointer must ignore the write; fetches moved the instruction pointer
		chk_regs();
		rd(4'hf, d8);
		chk8("unmapped", 8'h00, d8);
		t = 16'($urandom);
		cmd(cpurs_pkg::OP_JUMP, 8'h00, t);
		pc = t;
		chk_regs();
		wr(cpurs_pkg::REG_FLAGS, 8'h08);
		fl = 8'h68;
		wr(cpurs_pkg::REG_IDX_HI, 8'ha5);
		wr(cpurs_pkg::REG_IDX_LO, 8'h3c);
		// Two requests pending; the lower index must win once unmasked
		@(posedge i_clk);
		i_irq <= 8'h06;
		n_wr = 0;
		n_ack = 0;
		repeat (10) @(posedge i_clk);
		chk8("masked_pushes", 8'h00, 8'(n_wr));
		rd(cpurs_pkg::REG_STATUS, d8);
		chk8("status", {6'h00, cpurs_pkg::ST_IDLE}, d8);
		cmd(cpurs_pkg::OP_CLI, 8'h00, 16'h0000);
		// The acknowledge pulse reaches the monitor one edge after ready
		@(negedge i_clk);
		chk8("irq_index", 8'h01, 8'(ack_idx));
		chk8("ack_count", 8'h01, 8'(n_ack));
		chk8("stack_writes", 8'h05, 8'(n_wr));
		e = {8'h60, acc, 8'h3c, pc[15:8], pc[7:0]};
		for (int j = 0; j < 5; j++)
			chk8("stacked", e[j*8 +: 8], mem[sp - 16'(j)]);
		v = pc;
		sp = sp - 16'h5;
		pc = {mem[16'hfffa], mem[16'hfffb]};
		chk_regs();
		@(posedge i_clk);
		i_irq <= 8'h00;
		wr(cpurs_pkg::REG_ACC, ~acc);
		cmd(cpurs_pkg::OP_RTI, 8'h00, 16'h0000);
		sp = sp + 16'h5;
		pc = v;
		fl = 8'h60;
		chk_regs();
		b = 8'($urandom);
		t = 16'($urandom);
		cmd(cpurs_pkg::OP_EA_SP8, b, 16'h0000);
		chk16("ea", sp + 16'(b), o_ea);
		cmd(cpurs_pkg::OP_EA_SP16, 8'h00, t);
		chk16("ea", sp + t, o_ea);
		cmd(cpurs_pkg::OP_EA_IX, 8'h00, 16'h0000);
		chk16("ea", 16'ha53c, o_ea);
		t = 16'($urandom);
		cmd(cpurs_pkg::OP_LDHX, 8'h00, t);
		cmd(cpurs_pkg::OP_EA_IX, 8'h00, 16'h0000);
		chk16("ea", t, o_ea);
		rd16(cpurs_pkg::REG_IDX_HI, v);
		chk16("index_pair", t, v);
		t = 16'($urandom);
		cmd(cpurs_pkg::OP_CALL, 8'h00, t);
		// The last stack write lands in memory one edge after ready
		@(negedge i_clk);
		chk8("return_low", pc[7:0], mem[sp]);
		chk8("return_high", pc[15:8], mem[sp - 16'h1]);
		v = pc;
		pc = t;
		sp = sp - 16'h2;
		chk_regs();
		cmd(cpurs_pkg::OP_RET, 8'h00, 16'h0000);
		pc = v;
		sp = sp + 16'h2;
		chk_regs();
		cmd(cpurs_pkg::OP_CALL, 8'h00, t);
		cmd(cpurs_pkg::OP_RSP, 8'h00, 16'h0000);
		pc = t;
		sp = {sp[15:8], cpurs_pkg::SP_LOW_SET};
		chk_regs();
		do_reset();
		close_out();
	end
endmodule
